// >>> verilog/cesp_pkg.sv
// Shared constants, state and carrier types of the link error stop policy.
package cesp_pkg;

    // Register byte addresses on the Wishbone slave.
    localparam logic [7:0]  A_CFG    = 8'h00;
    localparam logic [7:0]  A_FREQ   = 8'h04;
    localparam logic [7:0]  A_STAT   = 8'h08;
    localparam logic [7:0]  A_MASK   = 8'h0C;
    localparam logic [7:0]  A_STATE  = 8'h10;
    localparam logic [7:0]  A_TERM   = 8'h14;
    localparam logic [7:0]  A_HIST   = 8'h18;

    // Reaction modes held in link_error_reaction_select.
    localparam logic [1:0]  MODE_COAST    = 2'h0;
    localparam logic [1:0]  MODE_DECEL    = 2'h1;
    localparam logic [1:0]  MODE_RESTART  = 2'h2;
    localparam logic [1:0]  MODE_FALLBACK = 2'h3;

    // Network command source choices; SRC_AUTO stands for the 9999 setting.
    localparam logic [1:0]  SRC_SERIAL = 2'h0;
    localparam logic [1:0]  SRC_OPTION = 2'h1;
    localparam logic [1:0]  SRC_AUTO   = 2'h2;

    // Fallback frequency limits in Hz and the keep-previous code.
    localparam logic [15:0] FREQ_MAX  = 16'h0190;
    localparam logic [15:0] FREQ_PREV = 16'h270F;

    // Output terminal function codes for the minor alarm.
    localparam logic [7:0]  FN_LF_POS = 8'h62;
    localparam logic [7:0]  FN_LF_NEG = 8'hC6;
    localparam int          NTERM     = 4;

    // Displayed fault codes; the values are arbitrary.
    localparam logic [7:0]  CODE_SER  = 8'hA1;
    localparam logic [7:0]  CODE_OPT  = 8'hA2;
    localparam logic [7:0]  CODE_NONE = 8'h00;

    // Status and mask bit positions.
    localparam int          EV_ERR    = 0;
    localparam int          EV_FAULT  = 1;
    localparam int          EV_MINOR  = 2;
    localparam int          EV_CLEAR  = 3;
    localparam int          EV_CONFL  = 4;
    localparam int          NEVT      = 5;

    // Write-one trip reset bit of the configuration register.
    localparam int          CFG_TRIP_CLR = 8;

    typedef struct packed {
        logic [1:0] src_sel;
        logic       rtu_off;
        logic       retry_off;
        logic [1:0] mode;
    } cesp_cfg_s;

    localparam cesp_cfg_s   CFG_RST = '{SRC_AUTO, 1'b0, 1'b0, MODE_COAST};
    localparam logic [31:0] TERM_RST = 32'h0000_0000;
    localparam logic [NEVT-1:0] MASK_RST = 5'h00;

    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_COAST,
        ST_DECEL_FLT,
        ST_FAULT,
        ST_DECEL_RST,
        ST_STOP_WAIT,
        ST_FALLBACK
    } cesp_state_e;

endpackage

// >>> verilog/cesp_policy.sv
// Link error stop policy with its Wishbone register file.
`timescale 1ns/1ps
module cesp_policy
    import cesp_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    // Link error events.
    input  wire logic        net_mode_i,
    input  wire logic        option_present_i,
    input  wire logic        err_on_option_i,
    input  wire logic        retry_excess_i,
    input  wire logic        signal_loss_i,
    input  wire logic        err_clear_i,
    // Drive state.
    input  wire logic        motor_stopped_i,
    input  wire logic [15:0] cur_freq_i,
    input  wire logic        run_cmd_i,
    input  wire logic [15:0] speed_cmd_i,
    input  wire logic        low_speed_input_i,
    // Drive reaction.
    output logic             coast_o,
    output logic             decel_o,
    output logic             fallback_o,
    output logic      [15:0] run_freq_o,
    output logic             hold_cmd_o,
    output logic             held_run_o,
    output logic      [15:0] held_speed_o,
    // Indication and fault outputs.
    output logic             fault_disp_o,
    output logic      [7:0]  fault_code_o,
    output logic             fault_relay_signal_o,
    output logic             alarm_bit_o,
    output logic             minor_link_alarm_o,
    output logic [NTERM-1:0] term_o,
    // Fault history strobes.
    output logic             hist_commit_o,
    output logic             hist_temp_o,
    output logic             hist_restore_o
);

    cesp_cfg_s         cfg_r;
    logic [15:0]       fb_set_r;
    logic [NEVT-1:0]   stat_r;
    logic [NEVT-1:0]   mask_r;
    logic [31:0]       term_fn_r;
    logic [7:0]        hist_r;
    logic [7:0]        temp_r;
    logic              temp_vld_r;
    cesp_state_e       st_r;
    cesp_state_e       st_nxt;
    logic [7:0]        code_r;
    logic              ack_r;
    logic [31:0]       rdat_r;
    logic              fault_r;
    logic              lf_r;
    logic              commit_r;
    logic              temp_wr_r;
    logic              restore_r;
    logic [15:0]       freq_r;
    logic              run_h_r;
    logic [15:0]       spd_h_r;
    logic              trip_clr;

    logic              wr_en;
    logic [31:0]       wmask;
    logic              conflict;
    logic              link_ok;
    logic              trig;
    logic [1:0]        eff_mode;
    logic              fb_skip;
    logic [15:0]       fb_freq;
    logic [NEVT-1:0]   ev;

    // Wishbone handshake: one wait cycle, ack drops after one cycle.
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
    always_comb
    begin
        for (int b = 0; b < 4; b++)
        begin
            wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
        end
    end
    assign trip_clr = wr_en && wb_adr_i == A_CFG && wb_sel_i[1]
                      && wb_dat_i[CFG_TRIP_CLR];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_r <= 1'b0;
        else
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_r     <= CFG_RST;
            fb_set_r  <= FREQ_PREV;
            mask_r    <= MASK_RST;
            term_fn_r <= TERM_RST;
        end
        else if (wr_en)
        begin
            unique case (wb_adr_i)
                A_CFG:
                    if (wb_sel_i[0])
                        cfg_r <= wb_dat_i[5:0];
                A_FREQ:
                    fb_set_r <= (fb_set_r & ~wmask[15:0])
                                | (wb_dat_i[15:0] & wmask[15:0]);
                A_MASK:
                    if (wb_sel_i[0])
                        mask_r <= wb_dat_i[NEVT-1:0];
                A_TERM:
                    term_fn_r <= (term_fn_r & ~wmask) | (wb_dat_i & wmask);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdat_r <= 32'h0000_0000;
        end
        else
        begin
            unique case (wb_adr_i)
                A_CFG:   rdat_r <= {26'h0, cfg_r};
                A_FREQ:  rdat_r <= {16'h0, fb_set_r};
                A_STAT:  rdat_r <= {27'h0, stat_r};
                A_MASK:  rdat_r <= {27'h0, mask_r};
                A_STATE: rdat_r <= {16'h0, code_r, 5'h0, st_r};
                A_TERM:  rdat_r <= term_fn_r;
                A_HIST:  rdat_r <= {15'h0, temp_vld_r, temp_r, hist_r};
                default: rdat_r <= 32'h0000_0000;
            endcase
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // Error qualification against the command source link.
    assign conflict = cfg_r.src_sel == SRC_AUTO && option_present_i;
    assign link_ok  = err_on_option_i ? cfg_r.src_sel == SRC_OPTION
                      : (cfg_r.src_sel == SRC_SERIAL
                         || (cfg_r.src_sel == SRC_AUTO
                             && !option_present_i));
    assign trig = net_mode_i && (retry_excess_i || signal_loss_i)
                  && (link_ok || conflict);
    assign eff_mode = conflict ? MODE_COAST : cfg_r.mode;
    assign fb_skip  = cfg_r.retry_off && cfg_r.rtu_off;
    // Out-of-range settings behave as the initial setting.
    assign fb_freq = (fb_set_r <= FREQ_MAX) ? fb_set_r : cur_freq_i;

    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            ST_NORMAL:
                if (trig)
                    unique case (eff_mode)
                        MODE_COAST:   st_nxt = ST_COAST;
                        MODE_DECEL:   st_nxt = ST_DECEL_FLT;
                        MODE_RESTART: st_nxt = ST_DECEL_RST;
                        MODE_FALLBACK:
                            if (!fb_skip)
                                st_nxt = ST_FALLBACK;
                    endcase
            ST_COAST, ST_FAULT:
                if (trip_clr)
                    st_nxt = ST_NORMAL;
            ST_DECEL_FLT:
                if (motor_stopped_i)
                    st_nxt = ST_FAULT;
            ST_DECEL_RST:
                if (err_clear_i)
                    st_nxt = ST_NORMAL;
                else if (motor_stopped_i)
                    st_nxt = ST_STOP_WAIT;
            ST_STOP_WAIT, ST_FALLBACK:
                if (err_clear_i)
                    st_nxt = ST_NORMAL;
            default: st_nxt = ST_NORMAL;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_r <= ST_NORMAL;
        else
            st_r <= st_nxt;
    end

    // Reaction outputs and held commands.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            code_r  <= CODE_NONE;
            freq_r  <= 16'h0000;
            run_h_r <= 1'b0;
            spd_h_r <= 16'h0000;
        end
        else if (st_r == ST_NORMAL && st_nxt != ST_NORMAL)
        begin
            code_r  <= (err_on_option_i && !conflict)
                       ? CODE_OPT : CODE_SER;
            freq_r  <= fb_freq;
            run_h_r <= run_cmd_i;
            spd_h_r <= speed_cmd_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fault_r <= 1'b0;
            lf_r    <= 1'b0;
        end
        else
        begin
            fault_r <= st_nxt == ST_COAST || st_nxt == ST_FAULT;
            lf_r    <= st_nxt == ST_FALLBACK;
        end
    end

    assign coast_o      = st_r == ST_COAST;
    assign decel_o      = st_r == ST_DECEL_FLT || st_r == ST_DECEL_RST
                          || st_r == ST_FAULT
                          || st_r == ST_STOP_WAIT;
    assign fallback_o   = st_r == ST_FALLBACK;
    assign run_freq_o   = freq_r;
    assign hold_cmd_o   = st_r == ST_DECEL_RST || st_r == ST_STOP_WAIT
                          || st_r == ST_FALLBACK;
    assign held_run_o   = run_h_r;
    assign held_speed_o = spd_h_r;
    assign fault_disp_o = st_r == ST_COAST || st_r == ST_FAULT
                          || st_r == ST_STOP_WAIT;
    assign fault_code_o = fault_disp_o ? code_r : CODE_NONE;
    assign fault_relay_signal_o = fault_r;
    assign alarm_bit_o          = fault_r;
    assign minor_link_alarm_o   = lf_r;

    genvar t;
    generate
        for (t = 0; t < NTERM; t++)
        begin : g_term
            assign term_o[t] = (term_fn_r[t*8 +: 8] == FN_LF_POS && lf_r)
                               || (term_fn_r[t*8 +: 8] == FN_LF_NEG
                                   && !lf_r);
        end
    endgenerate

    // Fault history: committed record plus a temporary overlay.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hist_r     <= CODE_NONE;
            temp_r     <= CODE_NONE;
            temp_vld_r <= 1'b0;
            commit_r   <= 1'b0;
            temp_wr_r  <= 1'b0;
            restore_r  <= 1'b0;
        end
        else
        begin
            commit_r  <= !fault_r && (st_nxt == ST_COAST
                                      || st_nxt == ST_FAULT);
            temp_wr_r <= st_r != st_nxt && (st_nxt == ST_STOP_WAIT
                         || st_nxt == ST_FALLBACK);
            restore_r <= temp_vld_r && st_nxt == ST_NORMAL
                         && st_r != ST_NORMAL;
            if (commit_r)
            begin
                hist_r <= code_r;
            end
            if (temp_wr_r)
            begin
                temp_r     <= code_r;
                temp_vld_r <= 1'b1;
            end
            else if (restore_r)
            begin
                temp_vld_r <= 1'b0;
            end
        end
    end
    assign hist_commit_o  = commit_r;
    assign hist_temp_o    = temp_wr_r;
    assign hist_restore_o = restore_r;

    // Sticky events; a set in the clearing cycle wins.
    assign ev[EV_ERR]   = st_r == ST_NORMAL && st_nxt != ST_NORMAL;
    assign ev[EV_FAULT] = commit_r;
    assign ev[EV_MINOR] = temp_wr_r && lf_r;
    assign ev[EV_CLEAR] = restore_r;
    assign ev[EV_CONFL] = net_mode_i && conflict;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            stat_r <= '0;
        else if (wr_en && wb_adr_i == A_STAT && wb_sel_i[0])
            stat_r <= (stat_r & ~wb_dat_i[NEVT-1:0]) | ev;
        else
            stat_r <= stat_r | ev;
    end
    assign irq_o = |(stat_r & mask_r);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    mode0_coast_a: assert property (st_r == ST_NORMAL && trig
        && eff_mode == MODE_COAST |=> ##1 coast_o && fault_relay_signal_o)
        else $error("mode 0 did not coast with fault");
    mode1_late_a: assert property (st_r == ST_DECEL_FLT
        |-> !fault_relay_signal_o && !fault_disp_o)
        else $error("mode 1 faulted before stop");
    mode2_nofault_a: assert property (hold_cmd_o |-> !alarm_bit_o)
        else $error("fault output in restart or fallback");
    reaccel_a: assert property (st_r == ST_DECEL_RST && err_clear_i
        |=> !decel_o && !fault_disp_o)
        else $error("no re-acceleration after clear");
    fb_freq_a: assert property (fallback_o && low_speed_input_i
        && fb_set_r <= FREQ_MAX && $stable(fb_set_r)
        |-> run_freq_o == fb_set_r)
        else $error("fallback frequency not applied");
    lf_term_a: assert property (term_fn_r[15:8] == FN_LF_NEG
        && $stable(term_fn_r) |-> term_o[1] != minor_link_alarm_o)
        else $error("negative minor alarm terminal wrong");
    relay_commit_a: assert property ($rose(alarm_bit_o)
        |-> hist_commit_o ##1 hist_r == code_r)
        else $error("fault not committed to history");
    netmode_gate_a: assert property (!net_mode_i
        && st_r == ST_NORMAL |=> st_r == ST_NORMAL)
        else $error("reaction outside network mode");
    both_off_a: assert property (st_r == ST_NORMAL && trig && fb_skip
        && eff_mode == MODE_FALLBACK |=> !fallback_o)
        else $error("fallback taken with checks disabled");
    opt_code_a: assert property (fault_disp_o && $past(st_r)
        == ST_NORMAL && $past(err_on_option_i) && !$past(conflict)
        |-> fault_code_o == CODE_OPT)
        else $error("option fault code not shown");
    restore_a: assert property (hist_restore_o
        |-> !fault_disp_o ##1 !temp_vld_r)
        else $error("history not restored");
    temp_hist_a: assert property ($rose(fallback_o) |-> hist_temp_o)
        else $error("no temporary record in fallback");

    cov_coast_c: cover property (st_r == ST_COAST);
    cov_restart_c: cover property (st_r == ST_DECEL_RST && err_clear_i);
    cov_wait_c: cover property (st_r == ST_STOP_WAIT ##1 st_r == ST_NORMAL);
    cov_fb_c: cover property (fallback_o && minor_link_alarm_o);

endmodule

// >>> bench/cesp_host_model.sv
// Host link and motor model for the link error stop policy bench.
`timescale 1ns/1ps
module cesp_host_model
(
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Drive side.
    input  wire logic decel_i,
    input  wire logic slow_i,
    // Link events and motor state.
    output logic      retry_excess_o,
    output logic      signal_loss_o,
    output logic      err_clear_o,
    output logic      motor_stopped_o
);
    logic [4:0] ramp_r;

    initial
    begin
        retry_excess_o = 1'b0;
        signal_loss_o = 1'b0;
        err_clear_o = 1'b0;
    end

    // Bench sets the panel source to serial, except in the option and auto conflict steps, so serial faults reach policy.
    // Pulse kinds: 0 retry excess, 1 signal loss, 2 error removed.
    task automatic ev(input int k);
        @(posedge clk_i);
        retry_excess_o <= (k == 0);
        signal_loss_o <= (k == 1);
        err_clear_o <= (k == 2);
        @(posedge clk_i);
        {retry_excess_o, signal_loss_o, err_clear_o} <= 3'b000;
    endtask

    // The motor reaches standstill some cycles after the ramp down starts.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !decel_i)
        begin
            ramp_r <= 5'h00;
            motor_stopped_o <= 1'b0;
        end
        else if (ramp_r == (slow_i ? 5'h14 : 5'h03))
            motor_stopped_o <= 1'b1;
        else
            ramp_r <= ramp_r + 5'h01;
    end
endmodule

// >>> bench/testbench.sv
// Self-checking bench of the link error stop policy.
`timescale 1ns/1ps
`define CHK(A, B) chk(32'(A), 32'(B))
module testbench
    import cesp_pkg::*;
;
    logic clk_i = 1'b0, rst_i, slow_i;
    logic wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, bsel;
    logic [31:0] wb_dat_i, wb_dat_o, rdata;
    logic net_mode_i, option_present_i, err_on_option_i;
    logic run_cmd_i, low_speed_input_i;
    logic [15:0] cur_freq_i, speed_cmd_i;
    logic retry_excess_i, signal_loss_i, err_clear_i, motor_stopped_i;
    logic wb_ack_o, irq_o, coast_o, decel_o, fallback_o, hold_cmd_o;
    logic held_run_o, fault_disp_o, fault_relay_signal_o, alarm_bit_o;
    logic minor_link_alarm_o, hist_commit_o, hist_temp_o, hist_restore_o;
    logic [15:0] run_freq_o, held_speed_o;
    logic [7:0] fault_code_o;
    logic [NTERM-1:0] term_o;
    logic [15:0] fv [4] = '{16'h0000, 16'h0190, 16'h0191, FREQ_PREV};
    logic [15:0] fe [4] = '{16'h0000, 16'h0190, 16'h0032, 16'h0032};
    int n_mismatch = 0, n_tests = 0, k;

    always #50 clk_i = ~clk_i;

    cesp_policy uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_o(irq_o), .net_mode_i(net_mode_i),
        .option_present_i(option_present_i),
        .err_on_option_i(err_on_option_i), .retry_excess_i(retry_excess_i),
        .signal_loss_i(signal_loss_i), .err_clear_i(err_clear_i),
        .motor_stopped_i(motor_stopped_i), .cur_freq_i(cur_freq_i),
        .run_cmd_i(run_cmd_i), .speed_cmd_i(speed_cmd_i),
        .low_speed_input_i(low_speed_input_i), .coast_o(coast_o),
        .decel_o(decel_o), .fallback_o(fallback_o), .run_freq_o(run_freq_o),
        .hold_cmd_o(hold_cmd_o), .held_run_o(held_run_o),
        .held_speed_o(held_speed_o), .fault_disp_o(fault_disp_o),
        .fault_code_o(fault_code_o),
        .fault_relay_signal_o(fault_relay_signal_o),
        .alarm_bit_o(alarm_bit_o), .minor_link_alarm_o(minor_link_alarm_o),
        .term_o(term_o), .hist_commit_o(hist_commit_o),
        .hist_temp_o(hist_temp_o), .hist_restore_o(hist_restore_o));

    cesp_host_model host (.clk_i(clk_i), .rst_i(rst_i), .decel_i(decel_o),
        .slow_i(slow_i), .retry_excess_o(retry_excess_i),
        .signal_loss_o(signal_loss_i), .err_clear_o(err_clear_i),
        .motor_stopped_o(motor_stopped_i));

    task summarize();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task tmo();
        n_mismatch++;
        summarize();
    endtask

    task chk(input logic [31:0] a, input logic [31:0] e);
        n_tests++;
        if (a !== e)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %0h expected %0h", $time, a, e);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Classic single Wishbone cycle; read data is taken at the ack edge.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, bsel, d};
        @(posedge clk_i);
        for (i = 0; i < 16 && wb_ack_o !== 1'b1; i++) @(posedge clk_i);
        rdata = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        if (i == 16)
            tmo();
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        `CHK(rdata, e);
    endtask

    task automatic wstop();
        int i;
        for (i = 0; i < 40 && motor_stopped_i !== 1'b1; i++) @(posedge clk_i);
        if (i == 40)
            tmo();
        cyc(3);
    endtask

    initial
    begin
        repeat (60000) @(posedge clk_i);
        tmo();
    end

    initial
    begin
        bsel = 4'hF;
        {rst_i, slow_i, net_mode_i} <= 3'b111;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        {wb_adr_i, wb_sel_i, wb_dat_i} <= {8'h00, 4'hF, 32'h0000_0000};
        {option_present_i, err_on_option_i} <= 2'b00;
        {run_cmd_i, low_speed_input_i} <= 2'b00;
        {cur_freq_i, speed_cmd_i} <= 32'h0000_0000;
        cyc(16);
        rst_i <= 1'b0;
        rdc(A_CFG, 32'h0000_0020);
        rdc(A_FREQ, 32'(FREQ_PREV));
        rdc(8'hFC, 32'h0);
        `CHK(irq_o, 1'b0);
        wr(A_MASK, 32'h1F);
        wr(A_CFG, 32'h00);
        host.ev(0);
        cyc(3);
        `CHK({coast_o, fault_disp_o, fault_relay_signal_o, alarm_bit_o, irq_o}, 5'h1F);
        `CHK(fault_code_o, CODE_SER);
        host.ev(2);
        cyc(3);
        `CHK(coast_o, 1'b1);
        rd(A_HIST);
        `CHK(rdata[7:0], CODE_SER);
        rd(A_STAT);
        `CHK(rdata[EV_FAULT], 1'b1);
        wr(A_MASK, 32'h00);
        cyc(2);
        `CHK(irq_o, 1'b0);
        wr(A_MASK, 32'h1F);
        wr(A_STAT, 32'h1F);
        cyc(2);
        `CHK(irq_o, 1'b0);
        wr(A_CFG, 32'h100);
        cyc(3);
        `CHK(coast_o, 1'b0);
        // Decelerate with fault after standstill, slow motor.
        wr(A_CFG, 32'h01);
        host.ev(1);
        cyc(3);
        `CHK({decel_o, coast_o, fault_relay_signal_o, fault_disp_o}, 4'h8);
        wstop();
        `CHK({fault_relay_signal_o, alarm_bit_o, fault_disp_o}, 3'h7);
        wr(A_CFG, 32'h101);
        // Restart mode; error removed first during ramp down.
        wr(A_CFG, 32'h02);
        run_cmd_i <= 1'b1;
        speed_cmd_i <= 16'h1234;
        cyc(2);
        host.ev(0);
        speed_cmd_i <= 16'h0000;
        cyc(3);
        `CHK({decel_o, hold_cmd_o, held_run_o}, 3'h7);
        `CHK(held_speed_o, 16'h1234);
        host.ev(2);
        cyc(3);
        `CHK({decel_o, fault_disp_o}, 2'h0);
        slow_i <= 1'b0;
        host.ev(1);
        wstop();
        `CHK({fault_disp_o, fault_relay_signal_o, alarm_bit_o}, 3'h4);
        rd(A_HIST);
        `CHK(rdata[16:8], {1'b1, CODE_SER});
        host.ev(2);
        cyc(3);
        `CHK({decel_o, fault_disp_o, fault_code_o}, 10'h000);
        rd(A_HIST);
        `CHK(rdata[16], 1'b0);
        rd(A_STAT);
        `CHK(rdata[EV_CLEAR], 1'b1);
        bsel = 4'h1;
        wr(A_FREQ, 32'h0000_ABCD);
        bsel = 4'hF;
        rdc(A_FREQ, 32'h0000_27CD);
        // Fallback run with terminal speed source active.
        wr(A_TERM, 32'h0000_C662);
        cur_freq_i <= 16'h0032;
        low_speed_input_i <= 1'b1;
        cyc(2);
        `CHK(term_o, 4'h2);
        wr(A_CFG, 32'h03);
        for (k = 0; k < 4; k++)
        begin
            wr(A_FREQ, 32'(fv[k]));
            host.ev(k % 2);
            cyc(3);
            `CHK({fallback_o, minor_link_alarm_o, fault_disp_o, fault_relay_signal_o}, 4'hC);
            `CHK(run_freq_o, fe[k]);
            `CHK(term_o, 4'h1);
            host.ev(2);
            cyc(3);
            `CHK({fallback_o, minor_link_alarm_o}, 2'h0);
        end
        wr(A_CFG, 32'h0F);
        host.ev(0);
        cyc(3);
        `CHK({fallback_o, coast_o, decel_o}, 3'h0);
        net_mode_i <= 1'b0;
        wr(A_CFG, 32'h00);
        host.ev(1);
        cyc(3);
        `CHK(coast_o, 1'b0);
        net_mode_i <= 1'b1;
        option_present_i <= 1'b1;
        err_on_option_i <= 1'b1;
        host.ev(0);
        cyc(3);
        `CHK(coast_o, 1'b0);
        wr(A_CFG, 32'h10);
        host.ev(0);
        cyc(3);
        `CHK({coast_o, fault_code_o}, {1'b1, CODE_OPT});
        wr(A_CFG, 32'h110);
        err_on_option_i <= 1'b0;
        wr(A_CFG, 32'h23);
        host.ev(1);
        cyc(3);
        `CHK({coast_o, fault_code_o}, {1'b1, CODE_SER});
        rd(A_STAT);
        `CHK(rdata[EV_CONFL], 1'b1);
        summarize();
    end
endmodule
